// >>> core/chirq_ctl.sv
// Channel interrupt indicators, source status and mode control over APB.
// Assumes event pulses come from logic on pclk; one active-low irq out.
`timescale 1ns/1ps
`default_nettype none

module chirq_ctl
	import chirq_pkg::*;
(
	input wire logic pclk, // APB clock
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction
	input wire logic [31:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic pready, // APB ready
	output logic [31:0] prdata, // APB read data
	output logic pslverr, // APB error on unmapped address
	input wire chirq_pkg::chan_evt_t [chirq_pkg::NUM_CHAN-1:0] chan_evt, // Event pulses per channel
	input wire logic [chirq_pkg::BYTE_W-1:0] concat_evt_2, // Concat path events 2
	input wire logic [chirq_pkg::BYTE_W-1:0] concat_evt_1, // Concat path events 1
	input wire logic [chirq_pkg::BYTE_W-1:0] concat_evt_0, // Concat path events 0
	output chirq_pkg::mode_ctl_t mode_ctl, // Mode controls to datapath
	output logic irq_n // Interrupt request, active low
);
	import chirq_pkg::*;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic [15:0] idx;
	logic acc, wr, rd, mapped;
	logic [BYTE_W-1:0] rdat;
	logic [NUM_CHAN-1:0] sel_chan;

	assign idx = paddr[17:2];
	assign acc = psel & penable;
	assign wr = acc & pwrite & mapped;
	assign rd = acc & ~pwrite & mapped;

	// Channel decode of a channel-indexed address; one-hot or zero.
	function automatic logic [NUM_CHAN-1:0] chan_hit(
		input logic [15:0] a,
		input logic [11:0] sub
	);
		logic [NUM_CHAN-1:0] h;
		h = '0;
		if (a[11:0] == sub && a[15:12] >= CHAN_DIGIT_MIN &&
			a[15:12] <= CHAN_DIGIT_MAX) begin
			h[2'(a[15:12] - CHAN_DIGIT_MIN)] = 1'b1;
		end
		return h;
	endfunction

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	logic [7:0] topo_q, mode_q, blk_en_q;
	logic [NUM_CHAN-1:0][NUM_SRC:0][7:0] src_en_q;
	logic [2:0][7:0] concat_en_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			topo_q <= TOPO_RESET;
			mode_q <= MODE_RESET;
		end else if (wr && idx == IDX_TOPOLOGY_CONTROL_HI) begin
			topo_q <= pwdata[7:0] & TOPO_WMASK;
		end else if (wr && idx == IDX_MODE_CONTROL_LO) begin
			mode_q <= pwdata[7:0] & MODE_WMASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blk_en_q <= BLK_EN_RESET;
			src_en_q <= '0;
			concat_en_q <= '0;
		end else if (wr) begin
			if (idx == IDX_BLOCK_IRQ_ENABLE) begin
				blk_en_q <= pwdata[7:0];
			end
			for (int c = 0; c < NUM_CHAN; c++) begin
				for (int s = 0; s <= NUM_SRC; s++) begin
					if (idx == IDX_SRC_ENABLE_BASE + 16'(c * 8 + s)) begin
						src_en_q[c][s] <= pwdata[7:0];
					end
				end
			end
			for (int b = 0; b < 3; b++) begin
				if (idx == IDX_SRC_ENABLE_BASE + 16'(NUM_CHAN * 8 + b)) begin
					concat_en_q[b] <= pwdata[7:0];
				end
			end
		end
	end

	always_comb begin
		mode_ctl.topology_select = topo_q[TOPO_LSB +: 2];
		mode_ctl.channel_kind_select = topo_q[KIND_LSB +: 4];
		mode_ctl.dual_bus = topo_q[DUAL_BUS_BIT];
		mode_ctl.packet_or_cell_select = mode_q[PKT_SEL_BIT];
		mode_ctl.tx_pll_off = mode_q[TX_PLL_OFF_BIT];
		mode_ctl.rx_pll_off = mode_q[RX_PLL_OFF_BIT];
		mode_ctl.soft_reset_bit = mode_q[SOFT_RESET_BIT];
	end

	// ----------------------------------------------------------------
	// Sticky source status, cleared by read; a new event wins.
	// ----------------------------------------------------------------
	logic [NUM_CHAN-1:0][NUM_SRC:0][7:0] st_q;
	logic [2:0][7:0] concat_q;
	logic [NUM_CHAN-1:0] hit_c1, hit_c0, hit_p2, hit_p1, hit_p0, hit_tx;
	logic [NUM_CHAN-1:0][NUM_SRC:0] hit_slot;
	logic concat_map;
	logic [NUM_CHAN-1:0] chan0_mask;

	// Channel 0 path bytes share their addresses with the concat path;
	// the topology decides which of the two a read reaches and clears.
	assign concat_map = (topo_q[TOPO_LSB +: 2] == TOPO_CONCAT_PLUS_DS3);
	assign chan0_mask = ~{{(NUM_CHAN-1){1'b0}}, concat_map};

	assign hit_c1 = chan_hit(idx, SUB_RX_CELL_IRQ_STATUS_1);
	assign hit_c0 = chan_hit(idx, SUB_RX_CELL_IRQ_STATUS_0);
	assign hit_p2 = chan_hit(idx, SUB_CHAN_PATH_IRQ_STATUS_2) &
		chan0_mask;
	assign hit_p1 = chan_hit(idx, SUB_CHAN_PATH_IRQ_STATUS_1) &
		chan0_mask;
	assign hit_p0 = chan_hit(idx, SUB_CHAN_PATH_IRQ_STATUS_0) &
		chan0_mask;
	assign hit_tx = chan_hit(idx, SUB_TX_CELL_IRQ_STATUS);

	// Which status byte of a channel a read addresses, slot NUM_SRC = tx.
	function automatic logic [NUM_SRC:0] slot_hit(input int c);
		logic [NUM_SRC:0] h;
		h = '0;
		h[SRC_PATH2] = hit_p2[c];
		h[SRC_PATH1] = hit_p1[c];
		h[SRC_PATH0] = hit_p0[c];
		h[SRC_CELL1] = hit_c1[c];
		h[SRC_CELL0] = hit_c0[c];
		h[NUM_SRC] = hit_tx[c];
		return h;
	endfunction

	// A read clears only the bits that it reported, so an event that
	// lands between the setup and access edges is not lost.
	function automatic logic [BYTE_W-1:0] clr_bits(input logic hit);
		return (rd && hit) ? prdata[BYTE_W-1:0] : '0;
	endfunction

	always_comb begin
		for (int c = 0; c < NUM_CHAN; c++) begin
			hit_slot[c] = slot_hit(c);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '0;
		end else begin
			for (int c = 0; c < NUM_CHAN; c++) begin
				for (int s = 0; s < NUM_SRC; s++) begin
					st_q[c][s] <= (st_q[c][s] &
						~clr_bits(hit_slot[c][s])) |
						chan_evt[c].rx[s];
				end
				st_q[c][NUM_SRC] <= (st_q[c][NUM_SRC] &
					~clr_bits(hit_slot[c][NUM_SRC])) |
					chan_evt[c].tx_cell;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			concat_q <= '0;
		end else begin
			concat_q[2] <= (concat_q[2] & ~clr_bits(concat_map &&
				idx == IDX_CONCAT_PATH_IRQ_STATUS_2)) |
				concat_evt_2;
			concat_q[1] <= (concat_q[1] & ~clr_bits(concat_map &&
				idx == IDX_CONCAT_PATH_IRQ_STATUS_1)) |
				concat_evt_1;
			concat_q[0] <= (concat_q[0] & ~clr_bits(concat_map &&
				idx == IDX_CONCAT_PATH_IRQ_STATUS_0)) |
				concat_evt_0;
		end
	end

	// ----------------------------------------------------------------
	// Channel indicators, one per functional block
	// ----------------------------------------------------------------
	logic [7:0] ind_path_q, ind_rxcell_q, ind_rxpkt_q, ind_txcell_q;
	logic [7:0] ind_path_d, ind_rxcell_d, ind_rxpkt_d, ind_txcell_d;

	always_comb begin
		ind_path_d = '0;
		ind_rxcell_d = '0;
		ind_rxpkt_d = '0;
		ind_txcell_d = '0;
		for (int c = 0; c < NUM_CHAN; c++) begin
			ind_path_d[c] = |(st_q[c][SRC_PATH2] & src_en_q[c][SRC_PATH2]) |
				|(st_q[c][SRC_PATH1] & src_en_q[c][SRC_PATH1]) |
				|(st_q[c][SRC_PATH0] & src_en_q[c][SRC_PATH0]);
			// Cell and packet status share a byte; mode picks the owner.
			ind_rxcell_d[c] = ~mode_q[PKT_SEL_BIT] &
				(|(st_q[c][SRC_CELL1] & src_en_q[c][SRC_CELL1]) |
				|(st_q[c][SRC_CELL0] & src_en_q[c][SRC_CELL0]));
			ind_rxpkt_d[c] = mode_q[PKT_SEL_BIT] &
				|(st_q[c][SRC_CELL0] & src_en_q[c][SRC_CELL0]);
			ind_txcell_d[c] = |(st_q[c][NUM_SRC] & src_en_q[c][NUM_SRC]);
		end
		// Concat path only exists in the concat-plus-DS3 topology.
		ind_path_d[CONCAT_IND_BIT] =
			(topo_q[TOPO_LSB +: 2] == TOPO_CONCAT_PLUS_DS3) &&
			|{concat_q[2] & concat_en_q[2], concat_q[1] & concat_en_q[1],
			concat_q[0] & concat_en_q[0]};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ind_path_q <= '0;
			ind_rxcell_q <= '0;
			ind_rxpkt_q <= '0;
			ind_txcell_q <= '0;
		end else begin
			ind_path_q <= ind_path_d;
			ind_rxcell_q <= ind_rxcell_d;
			ind_rxpkt_q <= ind_rxpkt_d;
			ind_txcell_q <= ind_txcell_d;
		end
	end

	// ----------------------------------------------------------------
	// Block status and interrupt; status is live, so reads do not clear it.
	// ----------------------------------------------------------------
	logic [7:0] blk_st;
	assign blk_st = {4'h0, |ind_txcell_q, |ind_rxpkt_q, |ind_rxcell_q,
		|ind_path_q};
	assign irq_n = ~|(blk_st & blk_en_q);

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	always_comb begin
		rdat = '0;
		mapped = 1'b1;
		if (idx == IDX_TOPOLOGY_CONTROL_HI) rdat = topo_q;
		else if (idx == IDX_MODE_CONTROL_LO) rdat = mode_q;
		else if (idx == IDX_PATH_CHANNEL_IRQ_INDICATOR) rdat = ind_path_q;
		else if (idx == IDX_RX_CELL_CHAN_IND) rdat = ind_rxcell_q;
		else if (idx == IDX_RX_PACKET_CHAN_IND) rdat = ind_rxpkt_q;
		else if (idx == IDX_TX_CELL_CHAN_IND) rdat = ind_txcell_q;
		else if (concat_map && idx == IDX_CONCAT_PATH_IRQ_STATUS_2)
			rdat = concat_q[2];
		else if (concat_map && idx == IDX_CONCAT_PATH_IRQ_STATUS_1)
			rdat = concat_q[1];
		else if (concat_map && idx == IDX_CONCAT_PATH_IRQ_STATUS_0)
			rdat = concat_q[0];
		else if (idx == IDX_BLOCK_IRQ_ENABLE) rdat = blk_en_q;
		else if (idx == IDX_BLOCK_IRQ_STATUS) rdat = blk_st;
		else begin
			mapped = 1'b0;
			for (int c = 0; c < NUM_CHAN; c++) begin
				for (int s = 0; s <= NUM_SRC; s++) begin
					if (hit_slot[c][s]) begin
						rdat = st_q[c][s];
						mapped = 1'b1;
					end
					if (idx == IDX_SRC_ENABLE_BASE + 16'(c * 8 + s)) begin
						rdat = src_en_q[c][s];
						mapped = 1'b1;
					end
				end
			end
			for (int b = 0; b < 3; b++) begin
				if (idx == IDX_SRC_ENABLE_BASE + 16'(NUM_CHAN * 8 + b)) begin
					rdat = concat_en_q[b];
					mapped = 1'b1;
				end
			end
		end
	end

	assign pready = 1'b1;
	assign pslverr = acc & ~mapped;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (psel && !penable && !pwrite) begin
			prdata <= {24'h000000, rdat};
		end
	end

endmodule // chirq_ctl

`default_nettype wire

// >>> core/chirq_pkg.sv
// Package for the channel interrupt indicator and mode control block.
// Assumes a 32-bit APB slave; offsets are register indices (word = 4*idx).
package chirq_pkg;

	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int NUM_CHAN = 3;
	localparam int NUM_SRC = 5;
	localparam int BYTE_W = 8;

	// ----------------------------------------------------------------
	// Register indices (printed offsets; byte address is four times)
	// ----------------------------------------------------------------
	localparam logic [15:0] IDX_TOPOLOGY_CONTROL_HI = 16'h0100;
	localparam logic [15:0] IDX_MODE_CONTROL_LO = 16'h0103;
	localparam logic [15:0] IDX_PATH_CHANNEL_IRQ_INDICATOR = 16'h0120;
	localparam logic [15:0] IDX_RX_CELL_CHAN_IND = 16'h0128;
	localparam logic [15:0] IDX_RX_PACKET_CHAN_IND = 16'h012a;
	localparam logic [15:0] IDX_TX_CELL_CHAN_IND = 16'h0127;
	localparam logic [15:0] IDX_CONCAT_PATH_IRQ_STATUS_2 = 16'h1189;
	localparam logic [15:0] IDX_CONCAT_PATH_IRQ_STATUS_1 = 16'h118a;
	localparam logic [15:0] IDX_CONCAT_PATH_IRQ_STATUS_0 = 16'h118b;
	// Low three hex digits of channel-indexed offsets; top digit is N + 1.
	localparam logic [11:0] SUB_RX_CELL_IRQ_STATUS_1 = 12'h70a;
	localparam logic [11:0] SUB_RX_CELL_IRQ_STATUS_0 = 12'h70b;
	localparam logic [11:0] SUB_CHAN_PATH_IRQ_STATUS_2 = 12'h189;
	localparam logic [11:0] SUB_CHAN_PATH_IRQ_STATUS_1 = 12'h18a;
	localparam logic [11:0] SUB_CHAN_PATH_IRQ_STATUS_0 = 12'h18b;
	localparam logic [11:0] SUB_TX_CELL_IRQ_STATUS = 12'hf0b;
	localparam logic [3:0] CHAN_DIGIT_MIN = 4'h1;
	localparam logic [3:0] CHAN_DIGIT_MAX = 4'h3;
	// Own registers: source enables and top-level interrupt status/mask.
	localparam logic [15:0] IDX_BLOCK_IRQ_ENABLE = 16'h0200;
	localparam logic [15:0] IDX_SRC_ENABLE_BASE = 16'h0210;
	localparam logic [15:0] IDX_BLOCK_IRQ_STATUS = 16'h0201;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int TOPO_LSB = 0;
	localparam int DUAL_BUS_BIT = 3;
	localparam int KIND_LSB = 4;
	localparam logic [7:0] TOPO_WMASK = 8'hfb;
	localparam logic [7:0] MODE_WMASK = 8'hc5;
	localparam int TX_PLL_OFF_BIT = 7;
	localparam int RX_PLL_OFF_BIT = 6;
	localparam int PKT_SEL_BIT = 2;
	localparam int SOFT_RESET_BIT = 0;
	localparam int CONCAT_IND_BIT = 4;
	localparam logic [7:0] TOPO_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] BLK_EN_RESET = 8'h00;

	// Source slots within a channel: event inputs and enable registers.
	typedef enum logic [2:0] {
		SRC_PATH2 = 3'h0,
		SRC_PATH1 = 3'h1,
		SRC_PATH0 = 3'h2,
		SRC_CELL1 = 3'h3,
		SRC_CELL0 = 3'h4
	} src_t;

	typedef enum logic [1:0] {
		TOPO_CONCAT_PLUS_DS3 = 2'h1,
		TOPO_STS1_X3 = 2'h0,
		TOPO_DS3_X3 = 2'h3
	} topology_t;

	// Mode controls driven to the datapath.
	typedef struct packed {
		logic [1:0] topology_select;
		logic [3:0] channel_kind_select;
		logic dual_bus;
		logic packet_or_cell_select;
		logic tx_pll_off;
		logic rx_pll_off;
		logic soft_reset_bit;
	} mode_ctl_t;

	// Per-channel source events: five bytes plus tx cell status.
	typedef struct packed {
		logic [NUM_SRC-1:0][BYTE_W-1:0] rx;
		logic [BYTE_W-1:0] tx_cell;
	} chan_evt_t;

endpackage : chirq_pkg

// >>> bench/chirq_ctl_asserts.sv
// Concurrent checks on the ports of chirq_ctl, bound to every instance.
// Assumes one pclk domain with presetn as its asynchronous reset.
`timescale 1ns/1ps
`default_nettype none

module chirq_ctl_asserts
	import chirq_pkg::*;
(
	input wire logic pclk, // clock
	input wire logic presetn, // reset
	input wire logic psel, // select
	input wire logic penable, // access phase
	input wire logic pwrite, // direction
	input wire logic [31:0] paddr, // address
	input wire logic [31:0] pwdata, // write data
	input wire logic pready, // ready
	input wire logic [31:0] prdata, // read data
	input wire logic pslverr, // error
	input wire chirq_pkg::mode_ctl_t mode_ctl, // mode controls
	input wire logic irq_n // interrupt
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic acc;
	logic [15:0] idx;
	assign acc = psel && penable;
	assign idx = paddr[17:2];

	AST_READY: assert property (acc |-> pready)
		else $error("access phase without ready");
	AST_ERR_PHASE: assert property (pslverr |-> acc)
		else $error("error outside access phase");
	AST_TOPO_WR: assert property (
		acc && pwrite && idx == IDX_TOPOLOGY_CONTROL_HI |=>
		mode_ctl.topology_select == $past(pwdata[1:0]) &&
		mode_ctl.channel_kind_select == $past(pwdata[7:4]))
		else $error("topology write not applied");
	AST_MODE_WR: assert property (
		acc && pwrite && idx == IDX_MODE_CONTROL_LO |=>
		mode_ctl.packet_or_cell_select == $past(pwdata[2]) &&
		mode_ctl.tx_pll_off == $past(pwdata[7]) &&
		mode_ctl.rx_pll_off == $past(pwdata[6]))
		else $error("mode write not applied");
	AST_MODE_HOLD: assert property (
		!(acc && pwrite) |=> $stable(mode_ctl))
		else $error("mode changed without a write");
	AST_TOPO_RD: assert property (
		acc && !pwrite && idx == IDX_TOPOLOGY_CONTROL_HI |->
		prdata[31:8] == 0 && !prdata[2] &&
		prdata[1:0] == mode_ctl.topology_select)
		else $error("topology read wrong");
	AST_MODE_RD: assert property (
		acc && !pwrite && idx == IDX_MODE_CONTROL_LO |->
		prdata[5:3] == 0 && !prdata[1] &&
		prdata[2] == mode_ctl.packet_or_cell_select)
		else $error("mode read wrong");
	AST_IND_RD: assert property (
		acc && !pwrite && idx == IDX_PATH_CHANNEL_IRQ_INDICATOR |->
		prdata[31:8] == 0 && prdata[7:5] == 0 && !prdata[3])
		else $error("indicator unused bits set");
	AST_UNMAP: assert property (
		acc && paddr[17:14] > CHAN_DIGIT_MAX |->
		pslverr && (pwrite || prdata == 0))
		else $error("channel digit above range accepted");
	AST_IRQ_MASK: assert property (
		acc && !pwrite && idx == IDX_BLOCK_IRQ_ENABLE &&
		prdata[3:0] == 0 |-> irq_n)
		else $error("interrupt raised with every block disabled");

endmodule // chirq_ctl_asserts

bind chirq_ctl chirq_ctl_asserts u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
	.mode_ctl(mode_ctl), .irq_n(irq_n));

`default_nettype wire

// >>> bench/testbench.sv
// Self-checking bench for chirq_ctl: APB master tasks and event pulses.
// Assumes the zero-wait slave and the event latencies of the hand-over.
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import chirq_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_n, se;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [7:0] c2, c1, c0;
	chan_evt_t [NUM_CHAN-1:0] ev;
	mode_ctl_t mc;
	int err_total, tests_run;

	chirq_ctl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .chan_evt(ev),
		.concat_evt_2(c2), .concat_evt_1(c1), .concat_evt_0(c0),
		.mode_ctl(mc), .irq_n(irq_n));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic stop_test;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// The wait is bounded so a slave that never answers ends the run.
	task automatic apb(input logic w, input logic [15:0] a,
			input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {14'h0000, a, 2'h0};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		se = pslverr;
		if (n >= 16) begin
			err_total++;
			$display("ERROR %0t bus timeout", $time);
			stop_test();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Slot 5 is tx cell, 6, 8 and 7 the concat bytes 0, 1 and 2.
	task automatic pulse(input int c, input int s);
		@(posedge pclk);
		case (s)
			5: ev[c].tx_cell <= 8'h5a;
			6: c0 <= 8'h5a;
			7: c2 <= 8'h5a;
			8: c1 <= 8'h5a;
			default: ev[c].rx[s] <= 8'h5a;
		endcase
		@(posedge pclk);
		ev <= '0;
		c0 <= 8'h00;
		c1 <= 8'h00;
		c2 <= 8'h00;
		repeat (3) @(posedge pclk);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		apb(1'b0, 16'h0100, 0);
		chk(rd, 0);
		apb(1'b0, 16'h0103, 0);
		chk(rd, 0);
		apb(1'b0, 16'h0120, 0);
		chk(rd, 0);
		apb(1'b1, 16'h0100, 32'hffff_ffff);
		apb(1'b0, 16'h0100, 0);
		chk(rd, 32'hfb);
		apb(1'b1, 16'h0103, 32'hffff_ffff);
		apb(1'b0, 16'h0103, 0);
		chk(rd, 32'hc5);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 16'h0100, 32'(i));
			apb(1'b1, 16'h0103, 32'(i[0]) << 2);
			@(negedge pclk);
			chk({30'h0, mc.topology_select}, 32'(i));
			chk({31'h0, mc.packet_or_cell_select}, 32'(i[0]));
		end
		apb(1'b1, 16'h4189, 32'hff);
		chk({31'h0, se}, 32'h1);
		apb(1'b0, 16'h4189, 0);
		chk(rd, 0);
		apb(1'b1, 16'h0103, 0);
		apb(1'b1, 16'h0100, 0);
		$display("test regs done");
	endtask

	// A reset in mid-run must bring every control back to zero.
	task automatic t_reset;
		apb(1'b1, 16'h0100, 32'hf9);
		apb(1'b1, 16'h0103, 32'h41);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		chk({21'h0, mc}, 32'h0);
		apb(1'b0, 16'h0100, 0);
		chk(rd, 0);
		apb(1'b0, 16'h0103, 0);
		chk(rd, 0);
		$display("test reset done");
	endtask

	task automatic t_evt(input int c, input int s, input int blk,
			input logic [15:0] en, input logic [15:0] st,
			input logic [15:0] ind, input logic [7:0] iv);
		apb(1'b1, 16'h0200, 32'h1 << blk);
		apb(1'b1, en, 32'hff);
		pulse(c, s);
		apb(1'b0, ind, 0);
		chk(rd, {24'h0, iv});
		chk({31'h0, irq_n}, 32'h0);
		apb(1'b0, 16'h0201, 0);
		chk(rd, 32'h1 << blk);
		apb(1'b0, st, 0);
		chk(rd, 32'h5a);
		apb(1'b0, st, 0);
		chk(rd, 32'h0);
		apb(1'b0, ind, 0);
		chk(rd, 32'h0);
		apb(1'b0, 16'h0201, 0);
		chk(rd, 32'h0);
		chk({31'h0, irq_n}, 32'h1);
		apb(1'b1, en, 0);
		$display("test event %h done", st);
	endtask

	task automatic t_mask;
		apb(1'b1, 16'h0200, 0);
		apb(1'b1, 16'h021a, 32'hff);
		pulse(1, 2);
		chk({31'h0, irq_n}, 32'h1);
		apb(1'b0, 16'h0200, 0);
		chk(rd, 32'h0);
		apb(1'b0, 16'h0120, 0);
		chk(rd, 32'h2);
		apb(1'b1, 16'h0200, 32'h1);
		@(negedge pclk);
		chk({31'h0, irq_n}, 32'h0);
		apb(1'b0, 16'h218b, 0);
		apb(1'b1, 16'h021a, 0);
		$display("test mask done");
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		ev = '0;
		c0 = 8'h00;
		c1 = 8'h00;
		c2 = 8'h00;
		err_total = 0;
		tests_run = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_reset();
		t_evt(1, 2, 0, 16'h021a, 16'h218b, 16'h0120, 8'h02);
		t_evt(0, 0, 0, 16'h0210, 16'h1189, 16'h0120, 8'h01);
		t_evt(2, 0, 0, 16'h0220, 16'h3189, 16'h0120, 8'h04);
		t_evt(1, 1, 0, 16'h0219, 16'h218a, 16'h0120, 8'h02);
		t_evt(2, 3, 1, 16'h0223, 16'h370a, 16'h0128, 8'h04);
		t_evt(0, 4, 1, 16'h0214, 16'h170b, 16'h0128, 8'h01);
		t_evt(2, 5, 3, 16'h0225, 16'h3f0b, 16'h0127, 8'h04);
		t_mask();
		apb(1'b1, 16'h0100, 32'h1);
		apb(1'b1, 16'h0103, 32'h4);
		t_evt(1, 4, 2, 16'h021c, 16'h270b, 16'h012a, 8'h02);
		t_evt(0, 6, 0, 16'h0228, 16'h118b, 16'h0120, 8'h10);
		t_evt(0, 7, 0, 16'h022a, 16'h1189, 16'h0120, 8'h10);
		t_evt(0, 8, 0, 16'h0229, 16'h118a, 16'h0120, 8'h10);
		stop_test();
	end
endmodule // testbench

`default_nettype wire
